// *** flash_host_pkg.sv ***
// constants and types for the flash host controller
`default_nettype none
package flash_host_pkg;
  // register byte offsets
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_ADDR = 6'h04;
  localparam logic [5:0] OFF_WDATA = 6'h08;
  localparam logic [5:0] OFF_CMD = 6'h0c;
  localparam logic [5:0] OFF_STAT = 6'h10;
  localparam logic [5:0] OFF_RDATA = 6'h14;
  localparam logic [5:0] OFF_ISTAT = 6'h18;
  localparam logic [5:0] OFF_IEN = 6'h1c;
  localparam logic [5:0] OFF_ICLR = 6'h20;
  // control and status bit positions
  localparam int CTRL_UNLOCK = 0;
  localparam int CTRL_VHH = 1;
  localparam int CTRL_PWRDN = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_LOCKED = 1;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REFUSED = 1;
  localparam int IRQ_W = 2;
  localparam int READY_BIT = 7;
  // command bytes understood by the flash
  localparam logic [7:0] CODE_ARRAY = 8'hff;
  localparam logic [7:0] CODE_PROG = 8'h40;
  localparam logic [7:0] CODE_ERASE = 8'h20;
  localparam logic [7:0] CODE_CONFIRM = 8'hd0;
  localparam logic [7:0] CODE_SUSPEND = 8'hb0;
  localparam logic [7:0] CODE_STATUS = 8'h70;
  localparam logic [7:0] CODE_CLEAR = 8'h50;
  localparam logic [7:0] CODE_IDENT = 8'h90;
  // operations software starts through the command register
  localparam logic [3:0] OP_WRITE = 4'h0;
  localparam logic [3:0] OP_READ = 4'h1;
  localparam logic [3:0] OP_PROGRAM = 4'h2;
  localparam logic [3:0] OP_ERASE = 4'h3;
  localparam logic [3:0] OP_SUSPEND = 4'h4;
  localparam logic [3:0] OP_RESUME = 4'h5;
  localparam logic [3:0] OP_STATUS = 4'h6;
  localparam logic [3:0] OP_CLEAR = 4'h7;
  localparam logic [3:0] OP_IDENT = 4'h8;
  localparam logic [3:0] OP_ARRAY = 4'h9;
  // timing
  localparam int CLK_NS = 10;
  localparam int T_WP_NS = 60;
  localparam int T_WPH_NS = 20;
  localparam int T_LOCK_NS = 100;
  localparam int CNT_W = 8;
  typedef enum logic [2:0] {S_IDLE, S_WLOW, S_WGAP, S_RLOW, S_RGAP} seq_t;
  typedef enum logic [1:0] {P_CMD, P_DATA, P_POLL, P_READ} phase_t;
endpackage
`default_nettype wire

// *** flash_host_ctrl.sv ***
// host controller driving an asynchronous command-set flash from AHB-Lite registers
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`default_nettype none
module flash_host_ctrl #(
  parameter int AW = 19,
  parameter int DW = 16,
  parameter int T_ACC_NS = 70,
  parameter int T_HZ_NS = 25
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic irq,
  output logic [AW-1:0] fl_addr,
  input wire logic [DW-1:0] dq_in,
  output logic [DW-1:0] dq_out,
  output logic dq_oe_n,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic wp_high,
  output logic vhh_en,
  output logic reset_powerdown_n
);
  localparam int WP_CYC = (flash_host_pkg::T_WP_NS + flash_host_pkg::CLK_NS - 1)
    / flash_host_pkg::CLK_NS;
  localparam int WPH_CYC = (flash_host_pkg::T_WPH_NS + flash_host_pkg::CLK_NS - 1)
    / flash_host_pkg::CLK_NS;
  // two extra cycles cover the data synchroniser
  localparam int RD_CYC = (T_ACC_NS + flash_host_pkg::CLK_NS - 1) / flash_host_pkg::CLK_NS + 2;
  localparam int HZ_CYC = (T_HZ_NS + flash_host_pkg::CLK_NS - 1) / flash_host_pkg::CLK_NS;
  localparam int LOCK_CYC = (flash_host_pkg::T_LOCK_NS + flash_host_pkg::CLK_NS - 1)
    / flash_host_pkg::CLK_NS;
  localparam int CW = flash_host_pkg::CNT_W;
  localparam int IW = flash_host_pkg::IRQ_W;

  // bus and register state
  logic [5:0] a_addr_ff, nxt_a_addr;
  logic a_wr_ff, nxt_a_wr, a_rd_ff, nxt_a_rd;
  logic hready_ff, nxt_hready;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic [2:0] ctrl_ff, nxt_ctrl;
  logic [AW-1:0] addr_ff, nxt_addr;
  logic [DW-1:0] wdata_ff, nxt_wdata;
  logic [3:0] go_op_ff, nxt_go_op;
  logic go_ff, nxt_go;
  logic [IW-1:0] istat_ff, nxt_istat, ien_ff, nxt_ien;
  logic irq_ff, nxt_irq;
  logic pwr_n_ff, nxt_pwr_n;
  // sequencer state
  flash_host_pkg::seq_t seq_ff, nxt_seq;
  flash_host_pkg::phase_t ph_ff, nxt_ph;
  logic [3:0] op_ff, nxt_op;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic ce_n_ff, nxt_ce_n, we_n_ff, nxt_we_n, oe_n_ff, nxt_oe_n;
  logic [DW-1:0] dq_out_ff, nxt_dq_out, rdata_ff, nxt_rdata;
  logic dq_oe_n_ff, nxt_dq_oe_n;
  logic busy_ff, nxt_busy, op_unlock_ff, nxt_op_unlock, ev_done;
  logic go_taken;
  logic [DW-1:0] dq_s1_ff, dq_s2_ff;
  // boot unlock state
  logic wp_ff, nxt_wp, vhh_ff, nxt_vhh, unlock_any_ff;
  logic [CW-1:0] lock_cnt_ff, nxt_lock_cnt;
  logic locked;

  assign locked = !unlock_any_ff && (lock_cnt_ff == '0);

  function automatic logic [DW-1:0] first_code(input logic [3:0] op, input logic [DW-1:0] wd);
    logic [7:0] c;
    c = flash_host_pkg::CODE_ARRAY;
    case (op)
      flash_host_pkg::OP_PROGRAM: c = flash_host_pkg::CODE_PROG;
      flash_host_pkg::OP_ERASE: c = flash_host_pkg::CODE_ERASE;
      flash_host_pkg::OP_SUSPEND: c = flash_host_pkg::CODE_SUSPEND;
      flash_host_pkg::OP_RESUME: c = flash_host_pkg::CODE_CONFIRM;
      flash_host_pkg::OP_STATUS: c = flash_host_pkg::CODE_STATUS;
      flash_host_pkg::OP_CLEAR: c = flash_host_pkg::CODE_CLEAR;
      flash_host_pkg::OP_IDENT: c = flash_host_pkg::CODE_IDENT;
      default: c = flash_host_pkg::CODE_ARRAY;
    endcase
    first_code = (op == flash_host_pkg::OP_WRITE) ? wd : DW'(c);
  endfunction

  // AHB-Lite slave and software registers
  always_comb
  begin
    nxt_a_addr = a_addr_ff;
    nxt_a_wr = 1'b0;
    nxt_a_rd = a_rd_ff;
    nxt_hready = hready_ff;
    nxt_hrdata = hrdata_ff;
    nxt_ctrl = ctrl_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_go_op = go_op_ff;
    // a suspend stays pending until the erase poll can take it
    nxt_go = go_ff && busy_ff && !go_taken;
    nxt_ien = ien_ff;
    nxt_istat = istat_ff;
    if (a_wr_ff)
    begin
      case (a_addr_ff)
        flash_host_pkg::OFF_CTRL: nxt_ctrl = hwdata[2:0];
        flash_host_pkg::OFF_ADDR: nxt_addr = hwdata[AW-1:0];
        flash_host_pkg::OFF_WDATA: nxt_wdata = hwdata[DW-1:0];
        flash_host_pkg::OFF_IEN: nxt_ien = hwdata[IW-1:0];
        flash_host_pkg::OFF_ICLR: nxt_istat = istat_ff & ~hwdata[IW-1:0];
        flash_host_pkg::OFF_CMD:
          // one operation at a time; only a suspend may break into a running erase
          if (go_ff || (busy_ff && !(hwdata[3:0] == flash_host_pkg::OP_SUSPEND
            && op_ff == flash_host_pkg::OP_ERASE)))
            nxt_istat[flash_host_pkg::IRQ_REFUSED] = 1'b1;
          else
          begin
            nxt_go = 1'b1;
            nxt_go_op = hwdata[3:0];
          end
        default: nxt_a_addr = a_addr_ff;
      endcase
    end
    // events set after the clear so a coincident event is kept
    if (ev_done)
      nxt_istat[flash_host_pkg::IRQ_DONE] = 1'b1;
    if (a_rd_ff)
    begin
      nxt_a_rd = 1'b0;
      nxt_hready = 1'b1;
      case (a_addr_ff)
        flash_host_pkg::OFF_CTRL: nxt_hrdata = 32'(ctrl_ff);
        flash_host_pkg::OFF_ADDR: nxt_hrdata = 32'(addr_ff);
        flash_host_pkg::OFF_WDATA: nxt_hrdata = 32'(wdata_ff);
        flash_host_pkg::OFF_CMD: nxt_hrdata = 32'(go_op_ff);
        flash_host_pkg::OFF_STAT: nxt_hrdata = 32'({locked, busy_ff});
        flash_host_pkg::OFF_RDATA: nxt_hrdata = 32'(rdata_ff);
        flash_host_pkg::OFF_ISTAT: nxt_hrdata = 32'(istat_ff);
        flash_host_pkg::OFF_IEN: nxt_hrdata = 32'(ien_ff);
        default: nxt_hrdata = 32'h0000_0000;
      endcase
    end
    else if (hsel && htrans[1] && hready)
    begin
      nxt_a_addr = haddr[5:0];
      nxt_a_wr = hwrite;
      nxt_a_rd = !hwrite;
      nxt_hready = hwrite;
    end
    nxt_irq = |(nxt_istat & nxt_ien);
    nxt_pwr_n = !nxt_ctrl[flash_host_pkg::CTRL_PWRDN];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_addr_ff <= 6'h00;
      a_wr_ff <= 1'b0;
      a_rd_ff <= 1'b0;
      hready_ff <= 1'b1;
      hrdata_ff <= 32'h0000_0000;
      ctrl_ff <= 3'h0;
      addr_ff <= '0;
      wdata_ff <= '0;
      go_op_ff <= 4'h0;
      go_ff <= 1'b0;
      istat_ff <= '0;
      ien_ff <= '0;
      irq_ff <= 1'b0;
      pwr_n_ff <= 1'b1;
    end
    else
    begin
      a_addr_ff <= nxt_a_addr;
      a_wr_ff <= nxt_a_wr;
      a_rd_ff <= nxt_a_rd;
      hready_ff <= nxt_hready;
      hrdata_ff <= nxt_hrdata;
      ctrl_ff <= nxt_ctrl;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      go_op_ff <= nxt_go_op;
      go_ff <= nxt_go;
      istat_ff <= nxt_istat;
      ien_ff <= nxt_ien;
      irq_ff <= nxt_irq;
      pwr_n_ff <= nxt_pwr_n;
    end
  end

  // flash bus sequencer
  always_comb
  begin
    logic do_w, do_r, fin;
    logic [DW-1:0] w_code;
    do_w = 1'b0;
    do_r = 1'b0;
    fin = 1'b0;
    w_code = '0;
    nxt_seq = seq_ff;
    nxt_ph = ph_ff;
    nxt_op = op_ff;
    nxt_cnt = cnt_ff;
    nxt_ce_n = ce_n_ff;
    nxt_we_n = we_n_ff;
    nxt_oe_n = oe_n_ff;
    nxt_dq_out = dq_out_ff;
    nxt_dq_oe_n = dq_oe_n_ff;
    nxt_rdata = rdata_ff;
    nxt_busy = busy_ff;
    nxt_op_unlock = op_unlock_ff;
    ev_done = 1'b0;
    go_taken = 1'b0;
    case (seq_ff)
      flash_host_pkg::S_IDLE:
        if (go_ff)
        begin
          nxt_op = go_op_ff;
          nxt_busy = 1'b1;
          nxt_op_unlock = ctrl_ff[flash_host_pkg::CTRL_UNLOCK];
          if (go_op_ff == flash_host_pkg::OP_READ)
          begin
            nxt_ph = flash_host_pkg::P_READ;
            do_r = 1'b1;
          end
          else
          begin
            nxt_ph = flash_host_pkg::P_CMD;
            w_code = first_code(go_op_ff, wdata_ff);
            do_w = 1'b1;
          end
        end
      flash_host_pkg::S_WLOW:
        if (cnt_ff == '0)
        begin
          // both strobes rise together so either framing reads the same
          nxt_we_n = 1'b1;
          nxt_ce_n = 1'b1;
          nxt_seq = flash_host_pkg::S_WGAP;
          nxt_cnt = CW'(WPH_CYC - 1);
        end
        else
          nxt_cnt = cnt_ff - 1'b1;
      flash_host_pkg::S_WGAP:
        if (cnt_ff != '0)
          nxt_cnt = cnt_ff - 1'b1;
        else
        begin
          nxt_dq_oe_n = 1'b1;
          if (ph_ff == flash_host_pkg::P_DATA)
          begin
            nxt_ph = flash_host_pkg::P_POLL;
            do_r = 1'b1;
          end
          else if (op_ff == flash_host_pkg::OP_PROGRAM)
          begin
            // setup is followed by the word itself
            nxt_ph = flash_host_pkg::P_DATA;
            w_code = wdata_ff;
            do_w = 1'b1;
          end
          else if (op_ff == flash_host_pkg::OP_ERASE)
          begin
            nxt_ph = flash_host_pkg::P_DATA;
            w_code = DW'(flash_host_pkg::CODE_CONFIRM);
            do_w = 1'b1;
          end
          else if (op_ff == flash_host_pkg::OP_SUSPEND)
          begin
            nxt_ph = flash_host_pkg::P_POLL;
            do_r = 1'b1;
          end
          else if (op_ff == flash_host_pkg::OP_STATUS || op_ff == flash_host_pkg::OP_IDENT)
          begin
            nxt_ph = flash_host_pkg::P_READ;
            do_r = 1'b1;
          end
          else
            fin = 1'b1;
        end
      flash_host_pkg::S_RLOW:
        if (cnt_ff == '0)
        begin
          nxt_rdata = dq_s2_ff;
          nxt_ce_n = 1'b1;
          nxt_oe_n = 1'b1;
          nxt_seq = flash_host_pkg::S_RGAP;
          nxt_cnt = CW'(HZ_CYC - 1);
        end
        else
          nxt_cnt = cnt_ff - 1'b1;
      flash_host_pkg::S_RGAP:
        if (cnt_ff != '0)
          nxt_cnt = cnt_ff - 1'b1;
        else if (ph_ff == flash_host_pkg::P_POLL && !rdata_ff[flash_host_pkg::READY_BIT])
        begin
          if (go_ff)
          begin
            // pending suspend breaks into the erase poll between reads
            go_taken = 1'b1;
            nxt_op = go_op_ff;
            nxt_ph = flash_host_pkg::P_CMD;
            w_code = DW'(flash_host_pkg::CODE_SUSPEND);
            do_w = 1'b1;
          end
          else
            do_r = 1'b1;
        end
        else
          fin = 1'b1;
      default: nxt_seq = flash_host_pkg::S_IDLE;
    endcase
    if (do_w)
    begin
      nxt_seq = flash_host_pkg::S_WLOW;
      nxt_ce_n = 1'b0;
      nxt_we_n = 1'b0;
      nxt_dq_out = w_code;
      nxt_dq_oe_n = 1'b0;
      nxt_cnt = CW'(WP_CYC - 1);
    end
    if (do_r)
    begin
      nxt_seq = flash_host_pkg::S_RLOW;
      nxt_ce_n = 1'b0;
      nxt_oe_n = 1'b0;
      nxt_cnt = CW'(RD_CYC - 1);
    end
    if (fin)
    begin
      nxt_seq = flash_host_pkg::S_IDLE;
      nxt_busy = 1'b0;
      ev_done = 1'b1;
    end
    // unlock stays up for the whole operation that started with it
    nxt_wp = (ctrl_ff[flash_host_pkg::CTRL_UNLOCK] || (nxt_busy && nxt_op_unlock))
      && !ctrl_ff[flash_host_pkg::CTRL_VHH];
    nxt_vhh = (ctrl_ff[flash_host_pkg::CTRL_UNLOCK] || (nxt_busy && nxt_op_unlock))
      && ctrl_ff[flash_host_pkg::CTRL_VHH];
    if (nxt_wp || nxt_vhh)
      nxt_lock_cnt = CW'(LOCK_CYC);
    else if (lock_cnt_ff != '0)
      nxt_lock_cnt = lock_cnt_ff - 1'b1;
    else
      nxt_lock_cnt = lock_cnt_ff;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      seq_ff <= flash_host_pkg::S_IDLE;
      ph_ff <= flash_host_pkg::P_CMD;
      op_ff <= 4'h0;
      cnt_ff <= '0;
      ce_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      dq_out_ff <= '0;
      dq_oe_n_ff <= 1'b1;
      rdata_ff <= '0;
      busy_ff <= 1'b0;
      op_unlock_ff <= 1'b0;
      wp_ff <= 1'b0;
      vhh_ff <= 1'b0;
      unlock_any_ff <= 1'b0;
      lock_cnt_ff <= '0;
      dq_s1_ff <= '0;
      dq_s2_ff <= '0;
    end
    else
    begin
      seq_ff <= nxt_seq;
      ph_ff <= nxt_ph;
      op_ff <= nxt_op;
      cnt_ff <= nxt_cnt;
      ce_n_ff <= nxt_ce_n;
      we_n_ff <= nxt_we_n;
      oe_n_ff <= nxt_oe_n;
      dq_out_ff <= nxt_dq_out;
      dq_oe_n_ff <= nxt_dq_oe_n;
      rdata_ff <= nxt_rdata;
      busy_ff <= nxt_busy;
      op_unlock_ff <= nxt_op_unlock;
      wp_ff <= nxt_wp;
      vhh_ff <= nxt_vhh;
      unlock_any_ff <= nxt_wp || nxt_vhh;
      lock_cnt_ff <= nxt_lock_cnt;
      dq_s1_ff <= dq_in;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  assign hreadyout = hready_ff;
  assign hrdata = hrdata_ff;
  assign hresp = 1'b0;
  assign irq = irq_ff;
  assign fl_addr = addr_ff;
  assign dq_out = dq_out_ff;
  assign dq_oe_n = dq_oe_n_ff;
  assign ce_n = ce_n_ff;
  assign we_n = we_n_ff;
  assign oe_n = oe_n_ff;
  assign wp_high = wp_ff;
  assign vhh_en = vhh_ff;
  assign reset_powerdown_n = pwr_n_ff;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_prog_setup_code: assert property (op_ff == flash_host_pkg::OP_PROGRAM
    && ph_ff == flash_host_pkg::P_CMD && !we_n_ff |-> dq_out_ff == DW'(flash_host_pkg::CODE_PROG))
    else $error("program setup byte wrong");
  a_array_code: assert property (op_ff == flash_host_pkg::OP_ARRAY && !we_n_ff
    |-> dq_out_ff == DW'(flash_host_pkg::CODE_ARRAY)) else $error("read array byte wrong");
  a_erase_confirm: assert property (op_ff == flash_host_pkg::OP_ERASE
    && ph_ff == flash_host_pkg::P_DATA && !we_n_ff |-> dq_out_ff == DW'(flash_host_pkg::CODE_CONFIRM))
    else $error("erase confirm byte wrong");
  a_status_code: assert property (op_ff == flash_host_pkg::OP_STATUS
    && ph_ff == flash_host_pkg::P_CMD && !we_n_ff |-> dq_out_ff == DW'(flash_host_pkg::CODE_STATUS))
    else $error("read status byte wrong");
  a_unlock_held: assert property (busy_ff && op_unlock_ff |-> wp_high || vhh_en)
    else $error("unlock dropped during operation");
  a_lock_wait: assert property ($fell(unlock_any_ff) |-> !locked [*8])
    else $error("locked reported before delay");
  a_write_gap: assert property ($rose(we_n_ff) |-> we_n_ff [*2])
    else $error("write high time too short");
  a_strobe_frame: assert property (!we_n_ff |-> !ce_n_ff && oe_n_ff && !dq_oe_n_ff)
    else $error("write strobe without chip enable or data");
  c_program_done: cover property (op_ff == flash_host_pkg::OP_PROGRAM && ev_done);
  c_erase_done: cover property (op_ff == flash_host_pkg::OP_ERASE && ev_done);
  c_refused: cover property (a_wr_ff && a_addr_ff == flash_host_pkg::OFF_CMD && busy_ff);
  c_suspend_taken: cover property (go_taken);
endmodule
`default_nettype wire

// *** flash_dev_model.sv ***
// behavioural model of the command-set flash behind the host controller
`default_nettype none
module flash_dev_model #(
  parameter int AW = 19,
  parameter int DW = 16,
  parameter int PROG_TICKS = 40,
  parameter int ERASE_TICKS = 300,
  parameter int BOOT_WORDS = 'h2000,
  parameter int LOCK_NS = 100,
  parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'ha5 // arbitrary value
) (
  input wire logic [AW-1:0] fl_addr,
  output logic [DW-1:0] dq_in,
  input wire logic [DW-1:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic wp_high,
  input wire logic vhh_en,
  input wire logic reset_powerdown_n,
  output int fault_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef enum logic [3:0] {M_ARRAY, M_STATUS, M_IDENT, M_PSETUP, M_PBUSY, M_ESETUP, M_EBUSY,
    M_ERR, M_SUSP_ST, M_SUSP_AR} mode_t;
  mode_t mode = M_ARRAY;
  logic [15:0] mem [int];
  logic [7:0] err_bits = 8'h00;
  logic [DW-1:0] last_q = '0;
  logic [DW-1:0] val;
  logic boot_op = 1'b0;
  int remain, saved;
  time fall_t = 0, rise_t = 0, unlock_off_t = 0;
  wire wr_strobe = ce_n | we_n;
  wire unlocked = wp_high | vhh_en;
  wire drv = !ce_n && !oe_n && reset_powerdown_n;
  wire busy = (mode == M_PBUSY) || (mode == M_EBUSY);
  wire suspended = (mode == M_SUSP_ST) || (mode == M_SUSP_AR);

  initial fault_cnt = 0;
  // boot block stays writable for the lock delay after the unlock drops
  always @(negedge unlocked) unlock_off_t = $time;
  function automatic logic boot_ok();
    return unlocked || ($time - unlock_off_t < LOCK_NS);
  endfunction

  always @(negedge wr_strobe)
  begin
    if ($time > 0 && $time - rise_t < 20) fault_cnt++;
    fall_t = $time;
  end

  // the write is taken at the earlier rising strobe
  always @(posedge wr_strobe)
  begin
    rise_t = $time;
    // strobes leaving unknown at reset are no write
    if (fall_t > 0 && reset_powerdown_n)
    begin
      if (rise_t - fall_t < 60 || dq_oe_n) fault_cnt++;
      take_write(dq_out[7:0]);
    end
  end

  task automatic take_write(input logic [7:0] c);
    int a;
    a = int'(fl_addr);
    case (mode)
      M_PSETUP:
      begin
        boot_op = a < BOOT_WORDS;
        if (boot_op && !boot_ok()) fault_cnt++;
        mem[a] = dq_out;
        remain = PROG_TICKS;
        mode = M_PBUSY;
      end
      M_PBUSY: ;
      M_EBUSY:
        if (c == 8'hb0)
        begin
          saved = remain;
          mode = M_SUSP_ST;
        end
      M_ESETUP:
        if (c == 8'hd0)
        begin
          boot_op = a < BOOT_WORDS;
          if (boot_op && !boot_ok()) fault_cnt++;
          mem.delete();
          remain = ERASE_TICKS;
          mode = M_EBUSY;
        end
        else
        begin
          err_bits = 8'h30;
          mode = M_ERR;
        end
      M_SUSP_ST, M_SUSP_AR:
        case (c)
          8'hd0:
          begin
            remain = saved;
            mode = M_EBUSY;
          end
          8'h70: mode = M_SUSP_ST;
          8'h10, 8'h40, 8'h90: ;
          default: mode = M_SUSP_AR;
        endcase
      default:
        case (c)
          8'hff: mode = M_ARRAY;
          8'h10, 8'h40: mode = M_PSETUP;
          8'h20: mode = M_ESETUP;
          8'h70: mode = M_STATUS;
          8'h90: mode = M_IDENT;
          8'h50:
          begin
            err_bits = 8'h00;
            mode = M_ARRAY;
          end
          default: mode = M_ARRAY;
        endcase
    endcase
  endtask

  // the embedded machine runs on its own time base
  always #10
    if (busy)
    begin
      if (boot_op && !unlocked) fault_cnt++;
      remain--;
      if (remain <= 0) mode = M_STATUS;
    end

  always @(negedge reset_powerdown_n)
  begin
    mode = M_ARRAY;
    err_bits = 8'h00;
  end

  always @(ce_n or oe_n or fl_addr or mode or err_bits)
  begin
    case (mode)
      M_ARRAY, M_SUSP_AR: val = mem.exists(int'(fl_addr)) ? mem[int'(fl_addr)] : 16'hffff;
      M_IDENT: val = {8'h00, fl_addr[0] ? PART_CODE : MAKER_CODE};
      default: val = {8'h00, !busy, suspended, err_bits[5:0]};
    endcase
    if (drv) last_q = val;
  end
  // released bus shows the inverse of the last value, not a held copy
  assign dq_in = drv ? val : ~last_q;
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the flash host controller
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp, irq, dq_oe_n, ce_n, we_n, oe_n;
  logic wp_high, vhh_en, reset_powerdown_n;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [18:0] fl_addr;
  logic [15:0] dq_in, dq_out;
  int fault_cnt, num_errors, total_checks;

  flash_host_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq), .fl_addr(fl_addr),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .wp_high(wp_high), .vhh_en(vhh_en), .reset_powerdown_n(reset_powerdown_n));
  flash_dev_model fm_u (.fl_addr(fl_addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .wp_high(wp_high), .vhh_en(vhh_en),
    .reset_powerdown_n(reset_powerdown_n), .fault_cnt(fault_cnt));

  always #5 hclk = ~hclk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic ahb(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {26'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  // start an op, let four cycles pass, then poll busy
  task automatic run(input logic [3:0] op);
    ahb(1'b1, flash_host_pkg::OFF_CMD, {28'h0, op});
    repeat (4) @(posedge hclk);
    ahb(1'b0, flash_host_pkg::OFF_STAT, 32'h0);
    while (rd[flash_host_pkg::STAT_BUSY] !== 1'b0) ahb(1'b0, flash_host_pkg::OFF_STAT, 32'h0);
  endtask

  task automatic flash_rd(input string what, input logic [3:0] op, input logic [15:0] exp);
    run(op);
    ahb(1'b0, flash_host_pkg::OFF_RDATA, 32'h0);
    chk(what, {16'h0, exp}, rd);
  endtask

  task automatic s_reset();
    chk("idle pins", 6'h3f, {ce_n, we_n, oe_n, dq_oe_n, reset_powerdown_n, ~irq});
    chk("unlock pins", 2'h0, {wp_high, vhh_en});
    chk("okay response", 32'h0, hresp);
    ahb(1'b0, 6'h3c, 32'h0);
    chk("unmapped read", 32'h0, rd);
  endtask

  task automatic s_program();
    ahb(1'b1, flash_host_pkg::OFF_CTRL, 32'h1);
    ahb(1'b1, flash_host_pkg::OFF_ADDR, 32'h10);
    ahb(1'b1, flash_host_pkg::OFF_WDATA, 32'h1234);
    run(flash_host_pkg::OP_PROGRAM);
    ahb(1'b0, flash_host_pkg::OFF_ISTAT, 32'h0);
    chk("done flag", 32'h1, rd);
    flash_rd("status after program", flash_host_pkg::OP_STATUS, 16'h0080);
    run(flash_host_pkg::OP_ARRAY);
    flash_rd("array word", flash_host_pkg::OP_READ, 16'h1234);
    flash_rd("ident word", flash_host_pkg::OP_IDENT, 16'h005a);
    run(flash_host_pkg::OP_CLEAR);
    flash_rd("array after clear", flash_host_pkg::OP_READ, 16'h1234);
  endtask

  task automatic s_irq();
    ahb(1'b1, flash_host_pkg::OFF_IEN, 32'h3);
    @(posedge hclk);
    chk("irq raised", 1'b1, irq);
    ahb(1'b1, flash_host_pkg::OFF_IEN, 32'h0);
    @(posedge hclk);
    chk("irq masked", 1'b0, irq);
    ahb(1'b1, flash_host_pkg::OFF_IEN, 32'h3);
    ahb(1'b1, flash_host_pkg::OFF_ICLR, 32'h3);
    @(posedge hclk);
    chk("irq cleared", 1'b0, irq);
    ahb(1'b0, flash_host_pkg::OFF_ISTAT, 32'h0);
    chk("status cleared", 32'h0, rd);
  endtask

  task automatic s_erase();
    ahb(1'b1, flash_host_pkg::OFF_CMD, {28'h0, flash_host_pkg::OP_ERASE});
    repeat (60) @(posedge hclk);
    run(flash_host_pkg::OP_SUSPEND);
    flash_rd("suspended status", flash_host_pkg::OP_READ, 16'h00c0);
    run(flash_host_pkg::OP_RESUME);
    // resume does not poll; let the rest of the erase run out
    repeat (300) @(posedge hclk);
    flash_rd("status after erase", flash_host_pkg::OP_READ, 16'h0080);
    run(flash_host_pkg::OP_ARRAY);
    flash_rd("erased word", flash_host_pkg::OP_READ, 16'hffff);
  endtask

  task automatic s_refused();
    ahb(1'b1, flash_host_pkg::OFF_ADDR, 32'h20);
    ahb(1'b1, flash_host_pkg::OFF_WDATA, 32'h5555);
    ahb(1'b1, flash_host_pkg::OFF_CMD, {28'h0, flash_host_pkg::OP_PROGRAM});
    run(flash_host_pkg::OP_STATUS);
    ahb(1'b0, flash_host_pkg::OFF_ISTAT, 32'h0);
    chk("refused flag", 32'h2, rd & 32'h2);
    run(flash_host_pkg::OP_ARRAY);
    flash_rd("programmed word", flash_host_pkg::OP_READ, 16'h5555);
  endtask

  task automatic s_cmd_error();
    ahb(1'b1, flash_host_pkg::OFF_WDATA, 32'h20);
    run(flash_host_pkg::OP_WRITE);
    ahb(1'b1, flash_host_pkg::OFF_WDATA, 32'hff);
    run(flash_host_pkg::OP_WRITE);
    flash_rd("erase error status", flash_host_pkg::OP_READ, 16'h00b0);
    run(flash_host_pkg::OP_CLEAR);
    flash_rd("status cleared", flash_host_pkg::OP_STATUS, 16'h0080);
    run(flash_host_pkg::OP_ARRAY);
  endtask

  task automatic s_lock();
    ahb(1'b1, flash_host_pkg::OFF_CTRL, 32'h3);
    ahb(1'b1, flash_host_pkg::OFF_ADDR, 32'h30);
    ahb(1'b1, flash_host_pkg::OFF_WDATA, 32'h0f0f);
    ahb(1'b0, flash_host_pkg::OFF_STAT, 32'h0);
    chk("unlocked flag", 32'h0, rd & 32'h2);
    run(flash_host_pkg::OP_PROGRAM);
    chk("high voltage unlock", 1'b1, vhh_en);
    ahb(1'b1, flash_host_pkg::OFF_CTRL, 32'h0);
    repeat (20) @(posedge hclk);
    ahb(1'b0, flash_host_pkg::OFF_STAT, 32'h0);
    chk("locked flag", 32'h2, rd & 32'h2);
    ahb(1'b1, flash_host_pkg::OFF_CTRL, 32'h4);
    @(posedge hclk);
    chk("power down pin", 1'b0, reset_powerdown_n);
    ahb(1'b1, flash_host_pkg::OFF_CTRL, 32'h0);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    num_errors = 0;
    total_checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_reset();
    s_program();
    s_irq();
    s_erase();
    s_refused();
    s_cmd_error();
    s_lock();
    chk("far side faults", 32'h0, fault_cnt);
    wrap_up();
  end

  initial
  begin
    #400000;
    num_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
